// [tb/core_branch_bit_and_data_memory_tb.sv]
// Self-checking bench for the branch, bit and stack unit.
// Assumes the unit decodes the classic opcode set on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "core_branch_map.svh"
module core_branch_bit_and_data_memory_tb;
	logic                     mclk, rst_n, instrValid, sfrWrEn;
	core_branch_pkg::instr_s  instr;
	logic [15:0]              instrPc;
	logic [7:0]               sfrAddr, sfrWrData, sfrRdData, stackPointer;
	logic                     ready, retire, progWrite, xdataWrite;
	logic                     codeReserved;
	logic [15:0]              nextPc;
	logic [1:0]               instrBytes;
	logic [2:0]               instrClocks;
	core_branch_pkg::xwrite_s extWr;
	int                       errTotal, compares;
	core_branch_unit u_dut (.mclk(mclk), .rst_n(rst_n),
		.instrValid(instrValid), .instr(instr), .instrPc(instrPc),
		.sfrWrEn(sfrWrEn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
		.sfrRdData(sfrRdData), .ready(ready), .retire(retire),
		.nextPc(nextPc), .instrBytes(instrBytes),
		.instrClocks(instrClocks), .progWrite(progWrite),
		.xdataWrite(xdataWrite), .extWr(extWr),
		.codeReserved(codeReserved), .stackPointer(stackPointer));
	////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic testDone;
		if (errTotal == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic ck(input logic [23:0] s, input logic [23:0] e);
		compares++;
		if (s !== e) begin
			errTotal++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfrWrEn = 1'b1;
		sfrAddr = a;
		sfrWrData = d;
		@(negedge mclk);
		sfrWrEn = 1'b0;
	endtask
	task automatic sfrRd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		sfrAddr = a;
		@(negedge mclk);
		ck(sfrRdData, e);
	endtask
	// Pulses packed as program write, data write, reserved target
	task automatic ex(input logic [7:0] op, a, b, input logic [15:0] pc,
		np, input logic [1:0] nb, input logic [2:0] nc, pl);
		int n;
		n = 0;
		@(negedge mclk);
		while (ready !== 1'b1) begin
			n++;
			if (n > 20) begin
				errTotal++;
				testDone();
			end
			@(negedge mclk);
		end
		instrValid = 1'b1;
		instr = {op, a, b};
		instrPc = pc;
		@(negedge mclk);
		instrValid = 1'b0;
		ck(retire, 1'b1);
		ck(ready, nc == 3'h1);
		ck({nextPc, 3'h0, instrBytes, instrClocks}, {np, 3'h0, nb, nc});
		ck({progWrite, xdataWrite, codeReserved}, pl);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		errTotal = 0;
		compares = 0;
		rst_n = 1'b0;
		instrValid = 1'b0;
		instr = '0;
		instrPc = 16'h0000;
		sfrWrEn = 1'b0;
		sfrAddr = 8'h81;
		sfrWrData = 8'h00;
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		ck(stackPointer, 8'h07);
		sfrRd(8'h81, 8'h07);
		ex(8'hD3, 8'h00, 8'h00, 16'h00FF, 16'h0100, 2'h1, 3'h1, 3'h0);
		ex(8'h40, 8'h10, 8'h00, 16'h0100, 16'h0112, 2'h2, 3'h4, 3'h0);
		ex(8'h50, 8'h10, 8'h00, 16'h0112, 16'h0114, 2'h2, 3'h2, 3'h0);
		ex(8'hB3, 8'h00, 8'h00, 16'h0114, 16'h0115, 2'h1, 3'h1, 3'h0);
		ex(8'h50, 8'hF0, 8'h00, 16'h0115, 16'h0107, 2'h2, 3'h4, 3'h0);
		ex(8'h80, 8'hFE, 8'h00, 16'h0180, 16'h0180, 2'h2, 3'h4, 3'h0);
		ex(8'hD2, 8'h00, 8'h00, 16'h0200, 16'h0202, 2'h2, 3'h2, 3'h0);
		ex(8'h20, 8'h00, 8'h20, 16'h0202, 16'h0225, 2'h3, 3'h5, 3'h0);
		ex(8'h30, 8'h00, 8'h20, 16'h0225, 16'h0228, 2'h3, 3'h3, 3'h0);
		ex(8'h10, 8'h00, 8'h00, 16'h0228, 16'h022B, 2'h3, 3'h5, 3'h0);
		ex(8'h20, 8'h00, 8'h10, 16'h022B, 16'h022E, 2'h3, 3'h3, 3'h0);
		ex(8'hD5, 8'h30, 8'h00, 16'h0300, 16'h0303, 2'h3, 3'h5, 3'h0);
		ex(8'hB4, 8'h00, 8'h00, 16'h0303, 16'h0306, 2'h3, 3'h3, 3'h0);
		ex(8'hB6, 8'h01, 8'h00, 16'h0306, 16'h0309, 2'h3, 3'h6, 3'h0);
		sfrWr(8'hE0, 8'h5A);
		ex(8'hC0, 8'hE0, 8'h00, 16'h0400, 16'h0402, 2'h2, 3'h2, 3'h0);
		ck(stackPointer, 8'h08);
		ex(8'hD0, 8'h82, 8'h00, 16'h0402, 16'h0404, 2'h2, 3'h2, 3'h0);
		ck(stackPointer, 8'h07);
		sfrRd(8'h82, 8'h5A);
		sfrWr(8'h83, 8'hFC);
		sfrWr(8'h8F, 8'h01);
		ex(8'hF0, 8'h00, 8'h00, 16'h0404, 16'h0405, 2'h1, 3'h3, 3'h5);
		ck(extWr, {16'hFC5A, 8'h5A});
		sfrWr(8'h8F, 8'h00);
		ex(8'hF0, 8'h00, 8'h00, 16'h0405, 16'h0406, 2'h1, 3'h3, 3'h2);
		ex(8'h73, 8'h00, 8'h00, 16'h0500, 16'hFCB4, 2'h1, 3'h4, 3'h1);
		ex(8'h02, 8'h12, 8'h34, 16'h0600, 16'h1234, 2'h3, 3'h5, 3'h0);
		ex(8'hE1, 8'h55, 8'h00, 16'h07FE, 16'h0F55, 2'h2, 3'h4, 3'h0);
		ex(8'hA5, 8'h00, 8'h00, 16'h0F55, 16'h0F56, 2'h1, 3'h1, 3'h0);
		// Bank one: its first register holds the byte pushed earlier
		sfrWr(8'hD0, 8'h08);
		ex(8'hD8, 8'h10, 8'h00, 16'h0700, 16'h0712, 2'h2, 3'h4, 3'h0);
		ex(8'hB8, 8'h59, 8'h20, 16'h0712, 16'h0715, 2'h3, 3'h3, 3'h0);
		ex(8'hD3, 8'h00, 8'h00, 16'h0715, 16'h0716, 2'h1, 3'h1, 3'h0);
		ex(8'hC3, 8'h00, 8'h00, 16'h0716, 16'h0717, 2'h1, 3'h1, 3'h0);
		sfrRd(8'hD0, 8'h08);
		ex(8'hD3, 8'h00, 8'h00, 16'h0717, 16'h0718, 2'h1, 3'h1, 3'h0);
		ex(8'h82, 8'h00, 8'h00, 16'h0718, 16'h071A, 2'h2, 3'h2, 3'h0);
		ex(8'h40, 8'h10, 8'h00, 16'h071A, 16'h071C, 2'h2, 3'h2, 3'h0);
		// Call and return with the stack in the upper, indirect-only RAM
		sfrWr(8'h81, 8'hA0);
		ex(8'h12, 8'h12, 8'h34, 16'h0800, 16'h1234, 2'h3, 3'h5, 3'h0);
		ck(stackPointer, 8'hA2);
		ex(8'h22, 8'h00, 8'h00, 16'h1234, 16'h0803, 2'h1, 3'h6, 3'h0);
		ck(stackPointer, 8'hA0);
		// Direct 0xA2 is a special register, not the return byte in RAM
		sfrWr(8'hE0, 8'h08);
		ex(8'hB5, 8'hA2, 8'h04, 16'h0803, 16'h080A, 2'h3, 3'h5, 3'h0);
		testDone();
	end
endmodule
`default_nettype wire

// [verilog/core_branch_map.svh]
// Constants of the branch, bit and data-memory block: opcodes, special
// register addresses, field positions, byte lengths and clock counts.
// Assumes inclusion by bare name from every file that decodes them.
`ifndef CORE_BRANCH_MAP_SVH
`define CORE_BRANCH_MAP_SVH

`define SP_RESET    8'h07
`define SFR_SP      8'h81
`define SFR_DPL     8'h82
`define SFR_DPH     8'h83
`define SFR_PROGRAM_STORE_CONTROL   8'h8F
`define SFR_PSW     8'hD0
`define SFR_ACC     8'hE0
`define PSW_RS0     3
`define PSW_RS1     4
`define PSW_CY      7
`define PROGRAM_STORE_CONTROL_WE    0
`define BIT_BASE    8'h20
`define CODE_LIMIT  16'hFBFF

`define OP_NOP      8'h00
`define OP_SPARE    8'hA5
`define OP_JBC      8'h10
`define OP_JB       8'h20
`define OP_JNB      8'h30
`define OP_JC       8'h40
`define OP_JNC      8'h50
`define OP_JZ       8'h60
`define OP_JNZ      8'h70
`define OP_SHORT_REL_JUMP     8'h80
`define OP_IJMP     8'h73
`define OP_FAR_JUMP     8'h02
`define OP_FAR_CALL    8'h12
`define OP_RET      8'h22
`define OP_INTERRUPT_RETURN     8'h32
`define OP_ORL_CB   8'h72
`define OP_ANL_CB   8'h82
`define OP_MOV_BC   8'h92
`define OP_MOV_CB   8'hA2
`define OP_ORL_CNB  8'hA0
`define OP_ANL_CNB  8'hB0
`define OP_CPL_B    8'hB2
`define OP_CPL_C    8'hB3
`define OP_CLR_B    8'hC2
`define OP_CLR_C    8'hC3
`define OP_BIT_SET_B   8'hD2
`define OP_BIT_SET_C   8'hD3
`define OP_CJ_AI    8'hB4
`define OP_CJ_AD    8'hB5
`define OP_DJ_D     8'hD5
`define OP_PUSH     8'hC0
`define OP_POP      8'hD0
`define OP_XWR_DP   8'hF0

`define LEN_1       2'h1
`define LEN_2       2'h2
`define LEN_3       2'h3
`define T_ONE       3'h1
`define T_BIT       3'h2
`define T_REL       3'h2
`define T_REL_TK    3'h4
`define T_BJ        3'h3
`define T_BJ_TK     3'h5
`define T_IND       3'h4
`define T_IND_TK    3'h6
`define T_JMP4      3'h4
`define T_FAR       3'h5
`define T_RET       3'h6
`define T_XWR       3'h3

`endif

// [verilog/core_branch_pkg.sv]
// Types shared by the branch unit and its testbench.
// Assumes the constants header is included where numbers are needed.
package core_branch_pkg;
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operandA;
		logic [7:0] operandB;
	} instr_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} xwrite_s;

	typedef enum logic {
		IDLE,
		HOLD
	} state_e;
endpackage

// [verilog/core_branch_unit.sv]
// Boolean and branch execution, data-memory decoding and the stack.
// Assumes instructions arrive whole, with their own address, from a fetch
// stage on mclk; special registers are reached by direct address.
`timescale 1ns/1ps
`default_nettype none
`include "core_branch_map.svh"
module core_branch_unit #(
	parameter bit LARGE_CODE = 1'b1 // 64 kB variant
) (
	input  wire logic                   mclk,         // System clock
	input  wire logic                   rst_n,        // Async reset
	input  wire logic                   instrValid,   // Instruction present
	input  wire core_branch_pkg::instr_s instr,       // Opcode, operands
	input  wire logic [15:0]            instrPc,      // First byte addr
	input  wire logic                   sfrWrEn,      // Register write
	input  wire logic [7:0]             sfrAddr,      // Register address
	input  wire logic [7:0]             sfrWrData,    // Register data
	output logic      [7:0]             sfrRdData,    // Register readback
	output logic                        ready,        // Can take instr
	output logic                        retire,       // Instr accepted
	output logic      [15:0]            nextPc,       // Next fetch addr
	output logic      [1:0]             instrBytes,   // Length taken
	output logic      [2:0]             instrClocks,  // Clocks used
	output logic                        progWrite,    // Code store pulse
	output logic                        xdataWrite,   // Ext data pulse
	output core_branch_pkg::xwrite_s    extWr,        // Write addr, data
	output logic                        codeReserved, // Reserved target
	output logic      [7:0]             stackPointer  // Stack pointer
);
	////////////////////////////////////////////////////////////////////
	logic [7:0]  processor_status_word, acc, dpLow, dpHigh, storeCtl;
	logic [7:0]  next_psw, next_acc, next_dpLow, next_dpHigh;
	logic [7:0]  next_storeCtl, next_sp, next_sfrRdData;
	logic [2:0]  waitCount, next_waitCount;
	logic [2:0]  next_instrClocks;
	logic [1:0]  next_instrBytes;
	logic [15:0] next_nextPc;
	logic        next_ready, next_retire, next_progWrite;
	logic        next_xdataWrite, next_codeReserved;
	core_branch_pkg::xwrite_s next_extWr;
	core_branch_pkg::state_e  state, next_state;

	logic [7:0]  op, b1, b2, rdAddrA, rdDataA, rdAddrB, rdDataB;
	logic [7:0]  bankBase, dirVal, bitByteAddr, byteVal, newByte;
	logic [7:0]  w0Addr, w0Data, w1Addr, w1Data, dwAddr, dwData;
	logic [7:0]  cmpL, cmpR, decVal;
	logic [15:0] pcAfter, target;
	logic [2:0]  regIdx;
	logic        accept, w0En, w1En, dwEn, taken, bitVal, isStackRd;

	assign accept = instrValid && ready;
	assign op     = instr.opcode;
	assign b1     = instr.operandA;
	assign b2     = instr.operandB;

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] sfrRead(input logic [7:0] a);
		case (a)
			`SFR_SP:    sfrRead = stackPointer;
			`SFR_PSW:   sfrRead = processor_status_word;
			`SFR_ACC:   sfrRead = acc;
			`SFR_DPL:   sfrRead = dpLow;
			`SFR_DPH:   sfrRead = dpHigh;
			`SFR_PROGRAM_STORE_CONTROL: sfrRead = storeCtl;
			default:    sfrRead = 8'h00;
		endcase
	endfunction

	function automatic logic isBitOp(input logic [7:0] o);
		case (o)
			`OP_JBC, `OP_JB, `OP_JNB, `OP_ORL_CB, `OP_ANL_CB,
			`OP_MOV_BC, `OP_MOV_CB, `OP_ORL_CNB, `OP_ANL_CNB,
			`OP_CPL_B, `OP_CLR_B, `OP_BIT_SET_B: isBitOp = 1'b1;
			default: isBitOp = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] relJump(input logic [15:0] base,
		input logic [7:0] rel);
		relJump = base + {{8{rel[7]}}, rel};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Addressing: ports A and B are chained so an indirect operand
	// resolves in the same cycle as its pointer register.
	always_comb begin
		bankBase = {3'h0, processor_status_word[`PSW_RS1], processor_status_word[`PSW_RS0], 3'h0};
		regIdx = op[3] ? op[2:0] : {2'h0, op[0]};
		isStackRd = (op == `OP_RET) || (op == `OP_INTERRUPT_RETURN) ||
			(op == `OP_POP);
		if (op == `OP_RET || op == `OP_INTERRUPT_RETURN)
			rdAddrA = stackPointer - 8'h01;
		else
			rdAddrA = bankBase | {5'h00, regIdx};
		if (b1[7])
			bitByteAddr = {b1[7:3], 3'h0};
		else
			bitByteAddr = `BIT_BASE + {4'h0, b1[6:3]};
		if (op[7:1] == 7'h5B) // indirect compare
			rdAddrB = rdDataA;
		else if (isStackRd)
			rdAddrB = stackPointer;
		else if (isBitOp(op))
			rdAddrB = bitByteAddr;
		else
			rdAddrB = b1;
		dirVal = b1[7] ? sfrRead(b1) : rdDataB;
		byteVal = bitByteAddr[7] ? sfrRead(bitByteAddr) : rdDataB;
		bitVal = byteVal[b1[2:0]];
	end

	data_memory u_ram (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.rdAddrA (rdAddrA),
		.rdDataA (rdDataA),
		.rdAddrB (rdAddrB),
		.rdDataB (rdDataB),
		.wrEn0   (w0En),
		.wrAddr0 (w0Addr),
		.wrData0 (w0Data),
		.wrEn1   (w1En),
		.wrAddr1 (w1Addr),
		.wrData1 (w1Data)
	);

	////////////////////////////////////////////////////////////////////
	// Execution: every effect is committed at the accept edge; the
	// remaining clocks of the instruction are spent in HOLD.
	always_comb begin
		next_psw = processor_status_word;
		next_acc = acc;
		next_dpLow = dpLow;
		next_dpHigh = dpHigh;
		next_storeCtl = storeCtl;
		next_sp = stackPointer;
		pcAfter = instrPc;
		target = instrPc;
		next_instrBytes = `LEN_1;
		next_instrClocks = `T_ONE;
		taken = 1'b0;
		newByte = byteVal;
		cmpL = acc;
		cmpR = b1;
		decVal = dirVal - 8'h01;
		w0En = 1'b0;
		w0Addr = 8'h00;
		w0Data = 8'h00;
		w1En = 1'b0;
		w1Addr = 8'h00;
		w1Data = 8'h00;
		dwEn = 1'b0;
		dwAddr = b1;
		dwData = 8'h00;
		next_progWrite = 1'b0;
		next_xdataWrite = 1'b0;
		next_extWr = extWr;
		if (op[4:0] == 5'h01 || op[4:0] == 5'h11 || isBitOp(op) ||
			op == `OP_PUSH || op == `OP_POP || op == `OP_DJ_D ||
			op[7:4] == 4'hB && op[3:2] != 2'h0 ||
			op == `OP_CJ_AI || op == `OP_CJ_AD ||
			op == `OP_FAR_JUMP || op == `OP_FAR_CALL)
			next_instrBytes = `LEN_3;
		else if (op[3:0] == 4'h0 || op[7:3] == 5'h1B)
			next_instrBytes = `LEN_2;
		if (op[3:0] == 4'h1 || op == `OP_PUSH || op == `OP_POP ||
			isBitOp(op) && op[3:0] == 4'h2 || op == `OP_ORL_CNB ||
			op == `OP_ANL_CNB)
			next_instrBytes = `LEN_2;
		if (op == `OP_JB || op == `OP_JNB || op == `OP_JBC ||
			op == `OP_DJ_D || op[7:2] == 6'h2D || op[7:3] == 5'h17)
			next_instrBytes = `LEN_3;
		if (op == `OP_NOP || op == `OP_SPARE || op == `OP_RET ||
			op == `OP_INTERRUPT_RETURN || op == `OP_IJMP || op[7:1] == 7'h79 ||
			op == `OP_XWR_DP || op == `OP_CLR_C ||
			op == `OP_BIT_SET_C || op == `OP_CPL_C)
			next_instrBytes = `LEN_1;
		if (accept)
			pcAfter = instrPc + {14'h0000, next_instrBytes};
		target = pcAfter;
		casez (op)
			`OP_CLR_C, `OP_BIT_SET_C, `OP_CPL_C: begin
				next_psw[`PSW_CY] = op[4] ? 1'b1 :
					(op[0] ? 1'b0 : !processor_status_word[`PSW_CY]);
				if (op == `OP_CPL_C)
					next_psw[`PSW_CY] = !processor_status_word[`PSW_CY];
			end
			`OP_ANL_CB, `OP_ANL_CNB, `OP_ORL_CB, `OP_ORL_CNB,
			`OP_MOV_CB: begin
				next_instrClocks = `T_BIT;
				case (op)
					`OP_ANL_CB:  next_psw[`PSW_CY] = processor_status_word[`PSW_CY] & bitVal;
					`OP_ANL_CNB: next_psw[`PSW_CY] = processor_status_word[`PSW_CY] & !bitVal;
					`OP_ORL_CB:  next_psw[`PSW_CY] = processor_status_word[`PSW_CY] | bitVal;
					`OP_ORL_CNB: next_psw[`PSW_CY] = processor_status_word[`PSW_CY] | !bitVal;
					default:     next_psw[`PSW_CY] = bitVal;
				endcase
			end
			`OP_MOV_BC, `OP_CLR_B, `OP_BIT_SET_B, `OP_CPL_B: begin
				next_instrClocks = `T_BIT;
				case (op)
					`OP_MOV_BC: newByte[b1[2:0]] = processor_status_word[`PSW_CY];
					`OP_CLR_B:  newByte[b1[2:0]] = 1'b0;
					`OP_BIT_SET_B: newByte[b1[2:0]] = 1'b1;
					default:    newByte[b1[2:0]] = !bitVal;
				endcase
				dwEn = 1'b1;
				dwAddr = bitByteAddr;
				dwData = newByte;
			end
			`OP_JC, `OP_JNC, `OP_JZ, `OP_JNZ, 8'b11011???: begin
				case (op)
					`OP_JC:  taken = processor_status_word[`PSW_CY];
					`OP_JNC: taken = !processor_status_word[`PSW_CY];
					`OP_JZ:  taken = (acc == 8'h00);
					`OP_JNZ: taken = (acc != 8'h00);
					default: taken = (rdDataA != 8'h01);
				endcase
				if (op[7:3] == 5'h1B) begin
					w0En = 1'b1;
					w0Addr = rdAddrA;
					w0Data = rdDataA - 8'h01;
				end
				next_instrClocks = taken ? `T_REL_TK : `T_REL;
				if (taken)
					target = relJump(pcAfter, b1);
			end
			`OP_JB, `OP_JNB, `OP_JBC, `OP_DJ_D, `OP_CJ_AI, `OP_CJ_AD,
			8'b1011011?, 8'b10111???: begin
				case (op)
					`OP_JB, `OP_JBC: taken = bitVal;
					`OP_JNB:         taken = !bitVal;
					`OP_DJ_D:        taken = (decVal != 8'h00);
					default:         taken = 1'b0;
				endcase
				if (op[7:4] == 4'hB) begin
					cmpL = op[3] ? rdDataA : (op[1] ? rdDataB : acc);
					cmpR = (op == `OP_CJ_AD) ? dirVal : b1;
					taken = (cmpL != cmpR);
					next_psw[`PSW_CY] = (cmpL < cmpR);
				end
				if (op == `OP_JBC && taken) begin
					newByte[b1[2:0]] = 1'b0;
					dwEn = 1'b1;
					dwAddr = bitByteAddr;
					dwData = newByte;
				end
				if (op == `OP_DJ_D) begin
					dwEn = 1'b1;
					dwData = decVal;
				end
				next_instrClocks = taken ? `T_BJ_TK : `T_BJ;
				if (op[7:1] == 7'h5B)
					next_instrClocks = taken ? `T_IND_TK : `T_IND;
				if (taken)
					target = relJump(pcAfter, b2);
			end
			`OP_SHORT_REL_JUMP: begin
				next_instrClocks = `T_JMP4;
				target = relJump(pcAfter, b1);
			end
			`OP_IJMP: begin
				next_instrClocks = `T_JMP4;
				target = {dpHigh, dpLow} + {8'h00, acc};
			end
			8'b???00001, 8'b???10001, `OP_FAR_JUMP, `OP_FAR_CALL: begin
				if (op[0]) begin
					next_instrClocks = `T_JMP4;
					target = {pcAfter[15:11], op[7:5], b1};
				end else begin
					next_instrClocks = `T_FAR;
					target = {b1, b2};
				end
				if (op[4]) begin
					w0En = 1'b1;
					w0Addr = stackPointer + 8'h01;
					w0Data = pcAfter[7:0];
					w1En = 1'b1;
					w1Addr = stackPointer + 8'h02;
					w1Data = pcAfter[15:8];
					next_sp = stackPointer + 8'h02;
				end
			end
			`OP_RET, `OP_INTERRUPT_RETURN: begin
				next_instrClocks = `T_RET;
				target = {rdDataB, rdDataA};
				next_sp = stackPointer - 8'h02;
			end
			`OP_PUSH: begin
				next_instrClocks = `T_BIT;
				w0En = 1'b1;
				w0Addr = stackPointer + 8'h01;
				w0Data = dirVal;
				next_sp = stackPointer + 8'h01;
			end
			`OP_POP: begin
				next_instrClocks = `T_BIT;
				next_sp = stackPointer - 8'h01;
				dwEn = 1'b1;
				dwData = rdDataB;
			end
			`OP_XWR_DP, 8'b1111001?: begin
				next_instrClocks = `T_XWR;
				next_extWr.addr = op[1] ? {8'h00, rdDataA} : {dpHigh, dpLow};
				next_extWr.data = acc;
				next_progWrite = storeCtl[`PROGRAM_STORE_CONTROL_WE];
				next_xdataWrite = !storeCtl[`PROGRAM_STORE_CONTROL_WE];
			end
			default: begin
				next_instrClocks = `T_ONE;
			end
		endcase
		if (dwEn && dwAddr[7]) begin
			case (dwAddr)
				`SFR_SP:    next_sp = dwData;
				`SFR_PSW:   next_psw = dwData;
				`SFR_ACC:   next_acc = dwData;
				`SFR_DPL:   next_dpLow = dwData;
				`SFR_DPH:   next_dpHigh = dwData;
				`SFR_PROGRAM_STORE_CONTROL: next_storeCtl = dwData;
				default:    next_acc = next_acc;
			endcase
		end else if (dwEn) begin
			w0En = 1'b1;
			w0Addr = dwAddr;
			w0Data = dwData;
		end
		if (!accept) begin
			w0En = 1'b0;
			w1En = 1'b0;
			next_psw = processor_status_word;
			next_sp = stackPointer;
			next_acc = acc;
			next_dpLow = dpLow;
			next_dpHigh = dpHigh;
			next_storeCtl = storeCtl;
			next_progWrite = 1'b0;
			next_xdataWrite = 1'b0;
			next_extWr = extWr;
			if (sfrWrEn) begin
				case (sfrAddr)
					`SFR_SP:    next_sp = sfrWrData;
					`SFR_PSW:   next_psw = sfrWrData;
					`SFR_ACC:   next_acc = sfrWrData;
					`SFR_DPL:   next_dpLow = sfrWrData;
					`SFR_DPH:   next_dpHigh = sfrWrData;
					`SFR_PROGRAM_STORE_CONTROL: next_storeCtl = sfrWrData;
					default:    next_acc = acc;
				endcase
			end
		end
		next_sfrRdData = sfrRead(sfrAddr);
	end

	////////////////////////////////////////////////////////////////////
	// Sequencing: an instruction of N clocks holds ready low N-1 cycles.
	always_comb begin
		next_state = state;
		next_waitCount = waitCount;
		next_ready = ready;
		next_retire = accept;
		next_nextPc = nextPc;
		next_codeReserved = 1'b0;
		case (state)
			core_branch_pkg::IDLE: begin
				if (accept) begin
					next_nextPc = target;
					next_codeReserved = LARGE_CODE &&
						(target > `CODE_LIMIT || next_progWrite &&
						next_extWr.addr > `CODE_LIMIT);
					if (next_instrClocks != `T_ONE) begin
						next_ready = 1'b0;
						next_waitCount = next_instrClocks - `T_BIT;
						next_state = core_branch_pkg::HOLD;
					end
				end
			end
			core_branch_pkg::HOLD: begin
				if (waitCount == 3'h0) begin
					next_ready = 1'b1;
					next_state = core_branch_pkg::IDLE;
				end else begin
					next_waitCount = waitCount - 3'h1;
				end
			end
			default: begin
				next_ready = 1'b1;
				next_state = core_branch_pkg::IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= core_branch_pkg::IDLE;
			waitCount <= 3'h0;
			ready <= 1'b1;
			retire <= 1'b0;
			nextPc <= 16'h0000;
			instrBytes <= `LEN_1;
			instrClocks <= `T_ONE;
			progWrite <= 1'b0;
			xdataWrite <= 1'b0;
			extWr <= '0;
			codeReserved <= 1'b0;
			stackPointer <= `SP_RESET;
			processor_status_word <= 8'h00;
			acc <= 8'h00;
			dpLow <= 8'h00;
			dpHigh <= 8'h00;
			storeCtl <= 8'h00;
			sfrRdData <= 8'h00;
		end else begin
			state <= next_state;
			waitCount <= next_waitCount;
			ready <= next_ready;
			retire <= next_retire;
			nextPc <= next_nextPc;
			if (accept) begin
				instrBytes <= next_instrBytes;
				instrClocks <= next_instrClocks;
			end
			progWrite <= next_progWrite;
			xdataWrite <= next_xdataWrite;
			extWr <= next_extWr;
			codeReserved <= next_codeReserved;
			stackPointer <= next_sp;
			processor_status_word <= next_psw;
			acc <= next_acc;
			dpLow <= next_dpLow;
			dpHigh <= next_dpHigh;
			storeCtl <= next_storeCtl;
			sfrRdData <= next_sfrRdData;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	carry_short_a: assert property (accept && op == `OP_CLR_C |=>
		ready && instrClocks == 3'h1 && !processor_status_word[`PSW_CY])
		else $error("carry clear not one clock");
	bit_pair_a: assert property (accept && op == `OP_ANL_CB |=>
		!ready ##1 ready) else $error("bit op not two clocks");
	jc_idle_a: assert property (accept && op == `OP_JC &&
		!processor_status_word[`PSW_CY] |=> instrClocks == 3'h2 &&
		nextPc == $past(instrPc) + 16'h0002)
		else $error("untaken jump wrong");
	jc_taken_a: assert property (accept && op == `OP_JC &&
		processor_status_word[`PSW_CY] |=> !ready [*3] ##1 ready)
		else $error("taken jump not four clocks");
	ind_cmp_a: assert property (accept && op[7:1] == 7'h5B |=>
		instrBytes == 2'h3 && (instrClocks == 3'h4 || instrClocks == 3'h6))
		else $error("indirect compare timing wrong");
	push_sp_a: assert property (accept && op == `OP_PUSH |=>
		stackPointer == $past(stackPointer) + 8'h01)
		else $error("push did not raise pointer");
	pop_sp_a: assert property (accept && op == `OP_POP &&
		b1 != `SFR_SP |=> stackPointer == $past(stackPointer) - 8'h01)
		else $error("pop did not lower pointer");
	page_keep_a: assert property (accept && op[4:0] == 5'h01 |=>
		nextPc[15:11] == $past(pcAfter[15:11]))
		else $error("page jump left its page");
	store_en_a: assert property (accept && op == `OP_XWR_DP &&
		storeCtl[`PROGRAM_STORE_CONTROL_WE] |=> progWrite && !xdataWrite)
		else $error("store write misrouted");
	spare_op_a: assert property (accept && op == `OP_SPARE |=>
		instrBytes == 2'h1 && instrClocks == 3'h1 && ready)
		else $error("spare opcode not a no-op");

	jbc_taken_c: cover property (accept && op == `OP_JBC && bitVal);
	far_call_c: cover property (accept && op == `OP_FAR_CALL);
	return_c: cover property (accept && op == `OP_RET ##1 retire);
endmodule
`default_nettype wire

// [verilog/data_memory.sv]
// 256-byte internal data RAM in flip-flops, two reads, two writes.
// Assumes write port 1 wins when both ports hit the same byte.
`timescale 1ns/1ps
`default_nettype none
module data_memory (
	input  wire logic       mclk,    // System clock
	input  wire logic       rst_n,   // Async reset, active low
	input  wire logic [7:0] rdAddrA, // Read address A
	output logic      [7:0] rdDataA, // Read data A
	input  wire logic [7:0] rdAddrB, // Read address B
	output logic      [7:0] rdDataB, // Read data B
	input  wire logic       wrEn0,   // Write enable 0
	input  wire logic [7:0] wrAddr0, // Write address 0
	input  wire logic [7:0] wrData0, // Write data 0
	input  wire logic       wrEn1,   // Write enable 1
	input  wire logic [7:0] wrAddr1, // Write address 1
	input  wire logic [7:0] wrData1  // Write data 1
);
	logic [7:0] mem [256];
	logic [7:0] next_mem [256];

	assign rdDataA = mem[rdAddrA];
	assign rdDataB = mem[rdAddrB];

	always_comb begin
		for (int i = 0; i < 256; i++) begin
			next_mem[i] = mem[i];
		end
		if (wrEn0) begin
			next_mem[wrAddr0] = wrData0;
		end
		if (wrEn1) begin
			next_mem[wrAddr1] = wrData1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= 8'h00;
			end
		end else begin
			mem <= next_mem;
		end
	end
endmodule
`default_nettype wire
